// [logic/cst_defines.svh]
`ifndef CST_DEFINES_SVH
`define CST_DEFINES_SVH

// ----------------------------------------------------------------
// Timer ratios and caps.
// ----------------------------------------------------------------
`define CST_PRE_DIV       10
`define CST_ADD_CAP_MULT  2

// ----------------------------------------------------------------
// Default time base and terminal counts.
// ----------------------------------------------------------------
`define CST_FAST_TICKS    32'd1000
`define CST_EXT_BASE      32'd10000
`define CST_INT_BASE      32'd10000

// ----------------------------------------------------------------
// Regulation reference codes, in 10 mV steps.
// ----------------------------------------------------------------
`define CST_VSET_CODE     8'hFA
`define CST_VPRE_CODE     8'h19

// ----------------------------------------------------------------
// Charge status encoding.
// ----------------------------------------------------------------
`define CST_STAT_OFF      2'h0
`define CST_STAT_DONE     2'h1
`define CST_STAT_FAST     2'h2
`define CST_STAT_PRE      2'h3

`endif

// [logic/cst_pkg.sv]
package cst_pkg;

  // ----------------------------------------------------------------
  // Charger phase states.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CST_OFF    = 3'b000,
    CST_PRE    = 3'b001,
    CST_FAST   = 3'b010,
    CST_DONE   = 3'b011,
    CST_FLT_HI = 3'b100,
    CST_FLT_LO = 3'b101
  } cst_state_e;

  typedef logic [7:0] cst_level_t;

endpackage

// [logic/cst_tick_if.sv]
interface cst_tick_if #(parameter int BASE_W = 32);
  logic                clr;
  logic                slow;
  cst_pkg::cst_level_t refLevel;
  cst_pkg::cst_level_t setLevel;
  logic [BASE_W-1:0]   baseCycles;
  logic                tick;
  logic                nomTick;

  modport gen  (input clr, slow, refLevel, setLevel, baseCycles, output tick, nomTick);
  modport user (output clr, slow, refLevel, setLevel, baseCycles, input tick, nomTick);
endinterface

// [logic/cst_tick_gen.sv]
module cst_tick_gen #(
  parameter int BASE_W = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  cst_tick_if.gen  tb
);
  import cst_pkg::*;

  localparam int ACC_W = BASE_W + 9;

  // ----------------------------------------------------------------
  // Elaboration check.
  // ----------------------------------------------------------------
  if (BASE_W < 2 || BASE_W > 32) begin : g_chk
    $error("BASE_W must lie between 2 and 32.");
  end

  logic [ACC_W-1:0]  acc;
  logic [BASE_W-1:0] nomCnt;

  // ----------------------------------------------------------------
  // Stretched step.
  // ----------------------------------------------------------------
  // The floor at half the reference keeps the period at most doubled.
  wire [8:0]       halfRef  = (9'(tb.refLevel) + 9'h001) >> 1;
  wire [7:0]       floorLvl = halfRef[7:0];
  wire [7:0]       clampLvl = (tb.setLevel > tb.refLevel) ? tb.refLevel :
                              (tb.setLevel < floorLvl) ? floorLvl : tb.setLevel;
  wire [7:0]       step     = tb.slow ? clampLvl : tb.refLevel;
  wire [ACC_W-1:0] span     = ACC_W'(tb.refLevel) * ACC_W'(tb.baseCycles);
  wire [ACC_W-1:0] sum      = acc + ACC_W'(step);
  wire             wrap     = (sum >= span);
  wire             nomWrap  = (nomCnt >= tb.baseCycles - BASE_W'(1));

  // ----------------------------------------------------------------
  // Accumulators.
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || tb.clr) begin
      acc     <= '0;
      tb.tick <= 1'b0;
    end else begin
      acc     <= wrap ? sum - span : sum;
      tb.tick <= wrap;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || tb.clr) begin
      nomCnt     <= '0;
      tb.nomTick <= 1'b0;
    end else begin
      nomCnt     <= nomWrap ? '0 : nomCnt + BASE_W'(1);
      tb.nomTick <= nomWrap;
    end
  end

endmodule

// [logic/cst_charger_safety_timer_fsm.sv]
`include "cst_defines.svh"

module cst_charger_safety_timer_fsm #(
  parameter int          BASE_W     = 32,
  parameter int          TICK_W     = 16,
  parameter logic [31:0] EXT_BASE   = `CST_EXT_BASE,
  parameter logic [31:0] INT_BASE   = `CST_INT_BASE,
  parameter logic [31:0] FAST_TICKS = `CST_FAST_TICKS,
  parameter logic [7:0]  VSET_CODE  = `CST_VSET_CODE,
  parameter logic [7:0]  VPRE_CODE  = `CST_VPRE_CODE
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          acPresent,
  input  wire logic          usbPresent,
  input  wire logic          uvloActive,
  input  wire logic          chargeEnable,
  input  wire logic          chargeRunBit,
  input  wire logic          packTempFault,
  input  wire logic          battBelowPrecharge,
  input  wire logic          battBelowRecharge,
  input  wire logic          battBelowDepleted,
  input  wire logic          terminationDone,
  input  wire logic          thermalLoopActive,
  input  wire logic          powerPathLoopActive,
  input  wire logic          timingResistorFloating,
  input  wire cst_pkg::cst_level_t currentSetLevel,
  output cst_pkg::cst_state_e chargeState,
  output logic [1:0]         chargeStatus,
  output logic               chargerOn,
  output logic               timeoutFault,
  output logic               removalPullupEn,
  output logic               timersHeld
);
  import cst_pkg::*;

  localparam int ADD_W = TICK_W + 2;

  // ----------------------------------------------------------------
  // Elaboration checks.
  // ----------------------------------------------------------------
  if (FAST_TICKS < `CST_PRE_DIV || FAST_TICKS >= (64'd1 << TICK_W)) begin : g_chk_ticks
    $error("FAST_TICKS must be at least the divider and fit TICK_W.");
  end
  if (EXT_BASE < 2 || INT_BASE < 2) begin : g_chk_base
    $error("Time base counts must be at least 2.");
  end

  // ----------------------------------------------------------------
  // Terminal counts.
  // ----------------------------------------------------------------
  localparam logic [TICK_W-1:0] FAST_TERM = TICK_W'(FAST_TICKS);
  localparam logic [TICK_W-1:0] PRE_TERM  = TICK_W'(FAST_TICKS / `CST_PRE_DIV);
  localparam logic [ADD_W-1:0]  FAST_CAP  = ADD_W'(FAST_TICKS * `CST_ADD_CAP_MULT);
  localparam logic [ADD_W-1:0]  PRE_CAP   = ADD_W'((FAST_TICKS / `CST_PRE_DIV) * `CST_ADD_CAP_MULT);

  // ----------------------------------------------------------------
  // First phase of a new cycle.
  // ----------------------------------------------------------------
  function automatic cst_state_e startPhase(input logic belowPre);
    startPhase = belowPre ? CST_PRE : CST_FAST;
  endfunction

  // Chooses between the two fault waits.
  function automatic cst_state_e faultPhase(input logic belowRch);
    faultPhase = belowRch ? CST_FLT_LO : CST_FLT_HI;
  endfunction

  cst_state_e        state;
  cst_state_e        next_state;
  logic              prevPower;
  logic              prevRun;
  logic              prevEnable;
  logic [TICK_W-1:0] preCount;
  logic [TICK_W-1:0] fastCount;
  logic [ADD_W-1:0]  addCount;

  cst_tick_if #(.BASE_W(BASE_W)) tickBus ();

  // ----------------------------------------------------------------
  // Input conditions.
  // ----------------------------------------------------------------
  wire inputPower = acPresent | usbPresent;
  wire powerGone  = !inputPower || uvloActive || !chargeEnable;
  wire runRise    = chargeRunBit && !prevRun;
  wire enableRise = chargeEnable && !prevEnable;
  wire powerRise  = inputPower && !prevPower;
  wire restartReq = runRise || enableRise || powerRise;
  wire suspend    = !chargeRunBit || packTempFault;
  wire loopActive = thermalLoopActive | powerPathLoopActive;
  wire inPre      = (state == CST_PRE);
  wire inFast     = (state == CST_FAST);
  wire clearAll   = powerGone || restartReq;

  // ----------------------------------------------------------------
  // Time base and slowdown selection.
  // ----------------------------------------------------------------
  wire [BASE_W-1:0] baseSel   = timingResistorFloating ? BASE_W'(INT_BASE) : BASE_W'(EXT_BASE);
  wire              slowPre   = inPre && loopActive && battBelowDepleted;
  wire              slowFast  = inFast && loopActive && battBelowRecharge;
  wire [ADD_W-1:0]  addCap    = inPre ? PRE_CAP : FAST_CAP;
  wire              addCapped = (addCount >= addCap);
  wire              slowReq   = (slowPre || slowFast) && !addCapped;
  wire              phaseMove = (next_state != state);

  assign tickBus.clr        = clearAll || phaseMove;
  assign tickBus.slow       = slowReq;
  assign tickBus.refLevel   = inPre ? VPRE_CODE : VSET_CODE;
  assign tickBus.setLevel   = currentSetLevel;
  assign tickBus.baseCycles = baseSel;

  cst_tick_gen #(
    .BASE_W (BASE_W)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tb      (tickBus)
  );

  // ----------------------------------------------------------------
  // Timer expiry.
  // ----------------------------------------------------------------
  // Suspend only gates the tick, so the counts are held, not cleared.
  wire runTick    = tickBus.tick && !suspend;
  wire preLast    = (preCount == PRE_TERM - TICK_W'(1));
  wire fastLast   = (fastCount == FAST_TERM - TICK_W'(1));
  wire preExpire  = inPre && runTick && preLast && battBelowPrecharge;
  wire fastExpire = inFast && !timingResistorFloating && runTick && fastLast && !terminationDone;

  // ----------------------------------------------------------------
  // Phase sequencing.
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      CST_OFF: begin
        next_state = startPhase(battBelowPrecharge);
      end
      CST_PRE: begin
        if (preExpire) begin
          next_state = faultPhase(battBelowRecharge);
        end else if (!battBelowPrecharge) begin
          next_state = CST_FAST;
        end
      end
      CST_FAST: begin
        if (terminationDone) begin
          next_state = CST_DONE;
        end else if (fastExpire) begin
          next_state = faultPhase(battBelowRecharge);
        end
      end
      CST_DONE: begin
        if (battBelowRecharge) begin
          next_state = startPhase(battBelowPrecharge);
        end
      end
      CST_FLT_LO: begin
        if (!battBelowRecharge) begin
          next_state = CST_FLT_HI;
        end
      end
      CST_FLT_HI: begin
        if (battBelowRecharge) begin
          next_state = startPhase(battBelowPrecharge);
        end
      end
      default: begin
        next_state = CST_OFF;
      end
    endcase
    if (powerGone) begin
      next_state = CST_OFF;
    end else if (restartReq) begin
      next_state = startPhase(battBelowPrecharge);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= CST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Edge history for restart detection.
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prevPower  <= 1'b0;
      prevRun    <= 1'b0;
      prevEnable <= 1'b0;
    end else begin
      prevPower  <= inputPower;
      prevRun    <= chargeRunBit;
      prevEnable <= chargeEnable;
    end
  end

  // ----------------------------------------------------------------
  // Precharge timer.
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || clearAll || !inPre || phaseMove) begin
      preCount <= '0;
    end else if (runTick) begin
      preCount <= preCount + TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Fast-charge timer.
  // ----------------------------------------------------------------
  // A floating timing pin keeps this timer cleared for as long as the pin floats.
  always_ff @(posedge ref_clk) begin
    if (rst || clearAll || !inFast || phaseMove || timingResistorFloating) begin
      fastCount <= '0;
    end else if (runTick) begin
      fastCount <= fastCount + TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Added time accounting.
  // ----------------------------------------------------------------
  // Counted in nominal periods so the cap is independent of stretch depth.
  always_ff @(posedge ref_clk) begin
    if (rst || clearAll || phaseMove) begin
      addCount <= '0;
    end else if (tickBus.nomTick && slowReq && !suspend) begin
      addCount <= addCount + ADD_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Status outputs.
  // ----------------------------------------------------------------
  wire faultNext = (next_state == CST_FLT_HI) || (next_state == CST_FLT_LO);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chargeStatus    <= `CST_STAT_OFF;
      chargerOn       <= 1'b0;
      timeoutFault    <= 1'b0;
      removalPullupEn <= 1'b0;
      timersHeld      <= 1'b0;
    end else begin
      case (next_state)
        CST_PRE:  chargeStatus <= suspend ? `CST_STAT_OFF : `CST_STAT_PRE;
        CST_FAST: chargeStatus <= suspend ? `CST_STAT_OFF : `CST_STAT_FAST;
        CST_DONE: chargeStatus <= `CST_STAT_DONE;
        default:  chargeStatus <= `CST_STAT_OFF;
      endcase
      chargerOn       <= (next_state == CST_PRE || next_state == CST_FAST) && !suspend;
      timeoutFault    <= faultNext;
      removalPullupEn <= (next_state == CST_FLT_LO);
      timersHeld      <= suspend && (next_state == CST_PRE || next_state == CST_FAST);
    end
  end

  assign chargeState = state;

endmodule

// [sim/cst_safety_checker.sv]
module cst_safety_checker
  import cst_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       acPresent,
  input wire logic       usbPresent,
  input wire logic       uvloActive,
  input wire logic       chargeEnable,
  input wire logic       chargeRunBit,
  input wire logic       packTempFault,
  input wire logic       battBelowRecharge,
  input wire logic       timingResistorFloating,
  input wire cst_state_e chargeState,
  input wire logic [1:0] chargeStatus,
  input wire logic       chargerOn,
  input wire logic       timeoutFault,
  input wire logic       removalPullupEn,
  input wire logic       timersHeld
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Input conditions.
  // ----------------------------------------------------------------
  // A rise of the run bit, enable or input power is a restart, so steady excludes those edges.
  sequence s_power;
    (acPresent || usbPresent) && chargeEnable && !uvloActive;
  endsequence
  sequence s_steady;
    s_power ##0 (chargeRunBit && !packTempFault && !$rose(chargeRunBit) && !$rose(chargeEnable)
      && !$rose(acPresent || usbPresent));
  endsequence
  sequence s_active;
    chargeState inside {CST_PRE, CST_FAST};
  endsequence

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  a_off_unpowered: assert property (!acPresent && !usbPresent |=> chargeState == CST_OFF)
    else $error("charger not off without input power");
  a_uvlo_clears: assert property (uvloActive |=> chargeState == CST_OFF && !timeoutFault)
    else $error("lockout did not clear state and fault");
  a_fault_status: assert property (timeoutFault |-> chargeStatus == 2'h0 && !chargerOn)
    else $error("fault not reported as off");
  a_pullup_low: assert property (removalPullupEn == (chargeState == CST_FLT_LO))
    else $error("pull-up not tied to low fault");
  a_low_release: assert property (chargeState == CST_FLT_LO ##0 s_steady ##0 !battBelowRecharge
    |=> chargeState == CST_FLT_HI)
    else $error("pull-up fault did not move to high fault");
  a_high_recover: assert property (chargeState == CST_FLT_HI ##0 s_steady ##0 battBelowRecharge
    |=> s_active ##0 !timeoutFault)
    else $error("high fault did not recover");
  a_done_again: assert property (chargeState == CST_DONE ##0 s_steady ##0 battBelowRecharge
    |=> s_active)
    else $error("no new cycle after done");
  a_suspend_hold: assert property (s_active ##0 packTempFault ##0 s_power |=> timersHeld && !chargerOn)
    else $error("suspend did not hold timers");
  a_float_nofault: assert property (timingResistorFloating && chargeState == CST_FAST
    |=> !timeoutFault)
    else $error("fast timer expired with floating pin");
endmodule

bind cst_charger_safety_timer_fsm cst_safety_checker cst_safety_checker_inst (.ref_clk, .rst, .acPresent,
  .usbPresent, .uvloActive, .chargeEnable, .chargeRunBit, .packTempFault, .battBelowRecharge,
  .timingResistorFloating, .chargeState, .chargeStatus, .chargerOn, .timeoutFault, .removalPullupEn,
  .timersHeld);

// [sim/cst_batt_model.sv]
module cst_batt_model
(
  input  wire logic [1:0] battLevel,
  input  wire logic       chargerOn,
  output logic            battBelowPrecharge,
  output logic            battBelowRecharge,
  output logic            battBelowDepleted,
  output logic            terminationDone
);
  timeunit 1ns;
  timeprecision 1ns;
  // Levels: 0 depleted, 1 below precharge, 2 below recharge, 3 full.
  // Comparators follow one level code so thresholds can never contradict.
  assign battBelowDepleted  = battLevel == 2'h0;
  assign battBelowPrecharge = battLevel <= 2'h1;
  assign battBelowRecharge  = battLevel <= 2'h2;
  // Current only tapers off while the charger really drives a full cell.
  assign terminationDone    = chargerOn && battLevel == 2'h3;
endmodule

// [sim/tb.sv]
module tb
  import cst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BASE = 4;
  localparam int FT   = 20;
  localparam int IBASE = 6;
  logic ref_clk = 0, rst = 1, acPresent = 0, usbPresent = 0, uvloActive = 0, chargeEnable = 1;
  logic chargeRunBit = 1, packTempFault = 0, thermalLoopActive = 0, powerPathLoopActive = 0;
  logic timingResistorFloating = 0, battBelowPrecharge, battBelowRecharge, battBelowDepleted;
  logic terminationDone, chargerOn, timeoutFault, removalPullupEn, timersHeld;
  logic [1:0]  battLevel = 2'h1, chargeStatus;
  logic [31:0] lfsr = 32'hD1E03B93, nextExp;
  cst_level_t  currentSetLevel = 8'h00;
  cst_state_e  chargeState, lastState, expQ[$];
  int          failures = 0, compares = 0, n, p0, f0;

  cst_charger_safety_timer_fsm #(.EXT_BASE(BASE), .INT_BASE(IBASE), .FAST_TICKS(FT))
    cst_charger_safety_timer_fsm_inst (.ref_clk, .rst, .acPresent, .usbPresent, .uvloActive,
    .chargeEnable, .chargeRunBit, .packTempFault, .battBelowPrecharge, .battBelowRecharge,
    .battBelowDepleted, .terminationDone, .thermalLoopActive, .powerPathLoopActive,
    .timingResistorFloating, .currentSetLevel, .chargeState, .chargeStatus, .chargerOn,
    .timeoutFault, .removalPullupEn, .timersHeld);
  cst_batt_model cst_batt_model_inst (.battLevel, .chargerOn, .battBelowPrecharge,
    .battBelowRecharge, .battBelowDepleted, .terminationDone);

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] next_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Every state change must match the oldest noted expectation.
  // ----------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (!rst && chargeState !== lastState) begin
      nextExp = 'x;
      if (expQ.size() > 0) nextExp = 32'(expQ.pop_front());
      check(32'(chargeState), nextExp);
    end
    lastState <= chargeState;
  end

  // Bounded so a stuck state ends the run instead of hanging it.
  task automatic wait_state(input cst_state_e s, output int cnt);
    cnt = 0;
    while (chargeState !== s && cnt < 2000) begin
      @(negedge ref_clk);
      cnt++;
    end
    if (cnt >= 2000) begin
      failures++;
      give_verdict();
    end
  endtask

  // Kind 0 toggles enable, 1 moves power from AC to USB, 2 toggles the run bit.
  task automatic restart(input int kind, input cst_state_e ph, input int susp, input bit expire,
                         output int cnt);
    if (kind != 2) expQ.push_back(CST_OFF);
    @(posedge ref_clk);
    if (kind == 0) chargeEnable <= 0;
    else if (kind == 1) acPresent <= 0;
    else chargeRunBit <= 0;
    repeat (3) @(posedge ref_clk);
    expQ.push_back(ph);
    if (kind == 0) chargeEnable <= 1;
    else if (kind == 1) usbPresent <= 1;
    else chargeRunBit <= 1;
    wait_state(ph, cnt);
    check(chargeStatus, (ph == CST_PRE) ? 2'h3 : 2'h2);
    check(chargerOn, 1);
    if (!expire) return;
    expQ.push_back(CST_FLT_LO);
    if (susp > 0) begin
      @(posedge ref_clk) packTempFault <= 1;
      repeat (susp - 1) @(posedge ref_clk);
      @(negedge ref_clk) check(timersHeld, 1);
      @(posedge ref_clk) packTempFault <= 0;
    end
    wait_state(CST_FLT_LO, cnt);
    // Counted from the end of the suspension, so the suspended stretch is added back.
    cnt += susp;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 0;
    expQ.push_back(CST_PRE);
    @(posedge ref_clk) acPresent <= 1;
    wait_state(CST_PRE, n);
    expQ.push_back(CST_FLT_LO);
    wait_state(CST_FLT_LO, p0);
    check(removalPullupEn, 1);
    check(chargeStatus, 2'h0);
    expQ.push_back(CST_FLT_HI);
    @(posedge ref_clk) battLevel <= 2'h3;
    wait_state(CST_FLT_HI, n);
    check(removalPullupEn, 0);
    expQ.push_back(CST_FAST);
    @(posedge ref_clk) battLevel <= 2'h2;
    wait_state(CST_FAST, n);
    expQ.push_back(CST_FLT_LO);
    wait_state(CST_FLT_LO, f0);
    check(f0 - p0, (FT - FT / 10) * BASE);
    restart(1, CST_FAST, 0, 1, n);
    check(n, f0);
    restart(2, CST_FAST, 30, 1, n);
    check(n inside {[f0 + 30 - BASE:f0 + 30 + BASE]}, 1);
    @(posedge ref_clk) battLevel <= 2'h1;
    restart(0, CST_PRE, 6, 1, n);
    check(n inside {[p0 + 6 - BASE:p0 + 6 + BASE]}, 1);
    @(posedge ref_clk) lfsr = next_lfsr(lfsr);
    currentSetLevel <= 8'(lfsr % 13);
    powerPathLoopActive <= 1;
    battLevel <= 2'h0;
    restart(0, CST_PRE, 0, 1, n);
    check(n inside {[p0 + BASE:p0 + 2 * BASE]}, 1);
    @(posedge ref_clk) battLevel <= 2'h1;
    restart(0, CST_PRE, 0, 1, n);
    check(n, p0);
    @(posedge ref_clk) lfsr = next_lfsr(lfsr);
    currentSetLevel <= 8'(lfsr % 125);
    thermalLoopActive <= 1;
    powerPathLoopActive <= 0;
    battLevel <= 2'h2;
    restart(0, CST_FAST, 0, 1, n);
    check(n inside {[f0 + (FT - 2) * BASE:f0 + (FT + 1) * BASE]}, 1);
    @(posedge ref_clk) thermalLoopActive <= 0;
    timingResistorFloating <= 1;
    battLevel <= 2'h1;
    restart(0, CST_PRE, 0, 1, n);
    check(n, p0 + (FT / 10) * (IBASE - BASE));
    @(posedge ref_clk) battLevel <= 2'h2;
    restart(0, CST_FAST, 0, 0, n);
    repeat (300) @(negedge ref_clk);
    check(timeoutFault, 0);
    expQ.push_back(CST_DONE);
    @(posedge ref_clk) battLevel <= 2'h3;
    wait_state(CST_DONE, n);
    expQ.push_back(CST_FAST);
    @(posedge ref_clk) battLevel <= 2'h2;
    wait_state(CST_FAST, n);
    expQ.push_back(CST_FLT_LO);
    @(posedge ref_clk) timingResistorFloating <= 0;
    wait_state(CST_FLT_LO, n);
    expQ.push_back(CST_OFF);
    @(posedge ref_clk) uvloActive <= 1;
    wait_state(CST_OFF, n);
    check(timeoutFault, 0);
    give_verdict();
  end
endmodule
